// ==== src/hiu_top.sv ====
// Interrupt collection unit: enable, sticky flags, mask, host interrupt line
`timescale 1ns/10ps
module hiu_top
  import hiu_pkg::*;
#(
  parameter int DEBOUNCE_CYC = HIU_DEBOUNCE_CYC
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire hiu_reg_req_t reg_req,
  output logic [7:0]        reg_rdata_q,
  input  wire hiu_src_t     src,
  input  wire logic         external_event_pin,
  output logic              host_int_q
);
  logic [7:0] enable_q;
  logic [7:0] flags_q;
  logic [7:0] mask_q;
  logic [7:0] icr_q;
  logic [7:0] set_vec;
  logic [7:0] pend;
  logic       ext_event;
  logic       wr_en;
  logic       wr_flags;
  logic       wr_mask;
  logic       wr_icr;

  assign wr_en    = reg_req.wr && reg_req.addr == HIU_OFF_ENABLE;
  assign wr_flags = reg_req.wr && reg_req.addr == HIU_OFF_FLAGS;
  assign wr_mask  = reg_req.wr && reg_req.addr == HIU_OFF_MASK;
  assign wr_icr   = reg_req.wr && reg_req.addr == HIU_OFF_INPUT_CTL;

  hiu_ext_cond #(
    .DEBOUNCE_CYC (DEBOUNCE_CYC)
  ) u_ext (
    .core_clk           (core_clk),
    .rst_n              (rst_n),
    .external_event_pin (external_event_pin),
    .debounce_en        (icr_q[HIU_ICR_DEBOUNCE]),
    .trig_mode          (hiu_trig_t'(icr_q[HIU_ICR_TRIG_HI:HIU_ICR_TRIG_LO])),
    .event_q            (ext_event)
  );

  // Raw events per source bit
  always_comb begin
    set_vec                 = 8'h00;
    set_vec[HIU_BIT_WAKE]   = src.wake;
    set_vec[HIU_BIT_EXT]    = ext_event;
    set_vec[HIU_BIT_I2C]    = src.i2c;
    set_vec[HIU_BIT_VSYNC]  = src.vsync;
    set_vec[HIU_BIT_KEYPAD] = src.keypad;
    set_vec[HIU_BIT_PROC]   = src.flash_dma_done || src.draw_done ||
                              src.block_transfer_engine_done;
    set_vec[HIU_BIT_PWM1]   = src.pwm1;
    set_vec[HIU_BIT_PWM0]   = src.pwm0;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      enable_q <= HIU_RST_ENABLE;
    end else if (wr_en) begin
      enable_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mask_q <= HIU_RST_MASK;
    end else if (wr_mask) begin
      mask_q <= reg_req.wdata;
    end
  end

  // Only the interrupt-related fields are kept; other bits read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      icr_q <= HIU_RST_INPUT_CTL;
    end else if (wr_icr) begin
      icr_q <= {reg_req.wdata[7:4], 4'h0};
    end
  end

  // Sticky flags; a new event outranks a clear in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < HIU_NUM_SRC; gi++) begin : g_flag
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          flags_q[gi] <= HIU_RST_FLAGS[gi];
        end else if (set_vec[gi] && enable_q[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (wr_flags && reg_req.wdata[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // Masked flags stay visible for polling but never reach the line
  assign pend = flags_q & enable_q & ~mask_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_int_q <= 1'b1;
    end else begin
      host_int_q <= icr_q[HIU_ICR_POL] ? |pend : ~|pend;
    end
  end

  // Registered read; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else begin
      unique case (reg_req.addr)
        HIU_OFF_ENABLE:    reg_rdata_q <= enable_q;
        HIU_OFF_FLAGS:     reg_rdata_q <= flags_q;
        HIU_OFF_MASK:      reg_rdata_q <= mask_q;
        HIU_OFF_INPUT_CTL: reg_rdata_q <= icr_q;
        default:           reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_flag_write;
    wr_flags;
  endsequence

  sequence s_mask_write;
    wr_mask;
  endsequence

  chk_w1c_clears: assert property (
    s_flag_write |=>
      (flags_q & $past(reg_req.wdata) & ~$past(set_vec & enable_q)) == 8'h00)
    else $error("flag written with one did not clear");

  chk_w0_keeps: assert property (
    s_flag_write |=>
      (~flags_q & $past(flags_q) & ~$past(reg_req.wdata)) == 8'h00)
    else $error("flag written with zero was lost");

  chk_set_wins: assert property (
    (set_vec & enable_q) != 8'h00 |=>
      (flags_q & $past(set_vec & enable_q)) == $past(set_vec & enable_q))
    else $error("enabled event did not set its flag");

  chk_disabled_quiet: assert property (
    1'b1 |=> (flags_q & ~$past(flags_q) & ~$past(enable_q)) == 8'h00)
    else $error("disabled source set its flag");

  chk_int_level: assert property (
    1'b1 |=> host_int_q ==
      ($past(icr_q[HIU_ICR_POL]) ? |$past(pend) : !(|$past(pend))))
    else $error("interrupt line does not match pending state");

  // Polarity may change on the next write, so only one cycle is judged
  chk_mask_quiet: assert property (
    (flags_q & enable_q) != 8'h00 &&
      (flags_q & enable_q & ~mask_q) == 8'h00 &&
      !icr_q[HIU_ICR_POL] |=> host_int_q)
    else $error("masked flag drove the interrupt");

  chk_vsync_flag: assert property (
    src.vsync && enable_q[HIU_BIT_VSYNC] |=> flags_q[HIU_BIT_VSYNC])
    else $error("vertical sync flag not set");

  chk_proc_shared: assert property (
    (src.flash_dma_done || src.draw_done ||
      src.block_transfer_engine_done) && enable_q[HIU_BIT_PROC]
      |=> flags_q[HIU_BIT_PROC])
    else $error("process complete flag not set");

  // Read data follows the offset of the cycle before
  chk_mask_write: assert property (
    s_mask_write |=> (mask_q == $past(reg_req.wdata)) ##1
      ($past(reg_req.addr) != HIU_OFF_MASK ||
        reg_rdata_q == $past(mask_q)))
    else $error("mask register write or readback wrong");

  chk_pwm0_mask: assert property (
    flags_q[HIU_BIT_PWM0] && enable_q[HIU_BIT_PWM0] &&
      !mask_q[HIU_BIT_PWM0] && icr_q[HIU_ICR_POL] |=> host_int_q)
    else $error("unmasked timer 0 flag did not raise the line");
endmodule

// ==== src/hiu_pkg.sv ====
// Package: register map, field layout and carriers of the interrupt unit
package hiu_pkg;
  localparam int         HIU_NUM_SRC       = 8;
  // Register offsets
  localparam logic [7:0] HIU_OFF_INPUT_CTL = 8'h03;
  localparam logic [7:0] HIU_OFF_ENABLE    = 8'h0b;
  localparam logic [7:0] HIU_OFF_FLAGS     = 8'h0c;
  localparam logic [7:0] HIU_OFF_MASK      = 8'h0d;
  // Reset values
  localparam logic [7:0] HIU_RST_ENABLE    = 8'h00;
  localparam logic [7:0] HIU_RST_FLAGS     = 8'h00;
  localparam logic [7:0] HIU_RST_MASK      = 8'h00;
  localparam logic [7:0] HIU_RST_INPUT_CTL = 8'h00;
  // Source bit positions
  localparam int         HIU_BIT_WAKE      = 7;
  localparam int         HIU_BIT_EXT       = 6;
  localparam int         HIU_BIT_I2C       = 5;
  localparam int         HIU_BIT_VSYNC     = 4;
  localparam int         HIU_BIT_KEYPAD    = 3;
  localparam int         HIU_BIT_PROC      = 2;
  localparam int         HIU_BIT_PWM1      = 1;
  localparam int         HIU_BIT_PWM0      = 0;
  // Input control fields
  localparam int         HIU_ICR_POL       = 7;
  localparam int         HIU_ICR_DEBOUNCE  = 6;
  localparam int         HIU_ICR_TRIG_HI   = 5;
  localparam int         HIU_ICR_TRIG_LO   = 4;
  // Debounce time in oscillator clocks, one oscillator clock per core clock
  localparam int         HIU_DEBOUNCE_OSC  = 1024;
  localparam int         HIU_DEBOUNCE_CYC  = HIU_DEBOUNCE_OSC;

  typedef enum logic [1:0] {
    HIU_TRIG_LOW_LEVEL  = 2'h0,
    HIU_TRIG_FALL_EDGE  = 2'h1,
    HIU_TRIG_HIGH_LEVEL = 2'h2,
    HIU_TRIG_RISE_EDGE  = 2'h3
  } hiu_trig_t;

  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hiu_reg_req_t;

  typedef struct packed {
    logic wake;
    logic i2c;
    logic vsync;
    logic keypad;
    logic flash_dma_done;
    logic draw_done;
    logic block_transfer_engine_done;
    logic pwm1;
    logic pwm0;
  } hiu_src_t;
endpackage

// ==== src/hiu_ext_cond.sv ====
// External event pin conditioner: optional debounce and trigger select
`timescale 1ns/10ps
module hiu_ext_cond
  import hiu_pkg::*;
#(
  parameter int DEBOUNCE_CYC = HIU_DEBOUNCE_CYC
) (
  input  wire logic      core_clk,
  input  wire logic      rst_n,
  input  wire logic      external_event_pin,
  input  wire logic      debounce_en,
  input  wire hiu_trig_t trig_mode,
  output logic           event_q
);
  localparam int CW = $clog2(DEBOUNCE_CYC + 1);

  logic          stable_q;
  logic          prev_q;
  logic          cand_q;
  logic [CW-1:0] cnt_q;
  logic          level;

  // Debounce: accept a new level only after it held the whole window
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cand_q   <= 1'b1;
      stable_q <= 1'b1;
      cnt_q    <= '0;
    end else begin
      cand_q <= external_event_pin;
      if (external_event_pin != cand_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(DEBOUNCE_CYC - 1)) begin
        stable_q <= cand_q;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign level = debounce_en ? stable_q : external_event_pin;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_q  <= 1'b1;
      event_q <= 1'b0;
    end else begin
      prev_q <= level;
      unique case (trig_mode)
        HIU_TRIG_LOW_LEVEL:  event_q <= !level;
        HIU_TRIG_FALL_EDGE:  event_q <= prev_q && !level;
        HIU_TRIG_HIGH_LEVEL: event_q <= level;
        HIU_TRIG_RISE_EDGE:  event_q <= !prev_q && level;
      endcase
    end
  end
endmodule

// ==== tb/hiu_host_mdl.sv ====
// Host side model: decodes the interrupt line by the configured polarity
`timescale 1ns/10ps
module hiu_host_mdl (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic host_int_q,
  input  wire logic pol_high,
  output logic      irq_seen
);
  // Combinational so the bench sees the line in the cycle it changes
  always_comb begin
    irq_seen = rst_n && (host_int_q === pol_high);
  end
endmodule

// ==== tb/host_interrupt_unit_tb.sv ====
// Self-checking bench of the host interrupt unit
`timescale 1ns/10ps
module host_interrupt_unit_tb;
  import hiu_pkg::*;
  localparam int         DEB      = 8;
  localparam logic [3:0] EXT_IDLE = 4'h3;
  logic         core_clk;
  logic         rst_n;
  logic         ext_pin;
  logic         pol;
  logic         irq;
  logic         host_int;
  logic [8:0]   src_v;
  logic [7:0]   rdata;
  hiu_reg_req_t req;
  int           fails;
  int           checks_done;
  // Flag bit of each source input, pwm0 first
  int           flag_bit [0:8] = '{0, 1, 2, 2, 2, 3, 4, 5, 7};

  hiu_top #(.DEBOUNCE_CYC(DEB)) dut (
    .core_clk          (core_clk),
    .rst_n             (rst_n),
    .reg_req           (req),
    .reg_rdata_q       (rdata),
    .src               (hiu_src_t'(src_v)),
    .external_event_pin(ext_pin),
    .host_int_q        (host_int)
  );
  hiu_host_mdl host (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .host_int_q(host_int),
    .pol_high  (pol),
    .irq_seen  (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask
  task automatic chk1(string n, logic e, logic g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    tick;
    req.addr = a;
    tick;
    checks_done++;
    if (rdata !== e) begin
      fails++;
      $display("ERROR reg %h expected %h seen %h", a, e, rdata);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    tick;
    req = '{1'b1, a, d};
    tick;
    req.wr = 1'b0;
  endtask
  // Event held for one cycle, then time for flag and line to follow
  task automatic pulse(logic [8:0] v);
    src_v = v;
    tick;
    src_v = '0;
    tick;
    tick;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic t_reset;
    rd_chk(HIU_OFF_ENABLE, 8'h00);
    rd_chk(HIU_OFF_FLAGS, 8'h00);
    rd_chk(HIU_OFF_MASK, 8'h00);
    chk1("line", 1'b1, host_int);
    wr(8'h20, 8'hff);
    rd_chk(8'h20, 8'h00);
  endtask
  task automatic t_sources;
    wr(HIU_OFF_ENABLE, 8'hff);
    for (int i = 0; i < 9; i++) begin
      pulse(9'h001 << i);
      rd_chk(HIU_OFF_FLAGS, 8'h01 << flag_bit[i]);
      chk1("irq", 1'b1, irq);
      wr(HIU_OFF_FLAGS, 8'h01 << flag_bit[i]);
      rd_chk(HIU_OFF_FLAGS, 8'h00);
      chk1("irq", 1'b0, irq);
    end
  endtask
  task automatic t_disabled;
    wr(HIU_OFF_ENABLE, 8'h00);
    pulse(9'h1ff);
    rd_chk(HIU_OFF_FLAGS, 8'h00);
    chk1("irq", 1'b0, irq);
  endtask
  task automatic t_mask;
    wr(HIU_OFF_ENABLE, 8'hff);
    wr(HIU_OFF_MASK, 8'h01);
    pulse(9'h001);
    rd_chk(HIU_OFF_MASK, 8'h01);
    rd_chk(HIU_OFF_FLAGS, 8'h01);
    chk1("irq", 1'b0, irq);
    wr(HIU_OFF_FLAGS, 8'hfe);
    rd_chk(HIU_OFF_FLAGS, 8'h01);
    wr(HIU_OFF_MASK, 8'h00);
    rd_chk(HIU_OFF_MASK, 8'h00);
    chk1("irq", 1'b1, irq);
    wr(HIU_OFF_FLAGS, 8'h01);
  endtask
  task automatic t_polarity;
    wr(HIU_OFF_INPUT_CTL, 8'h8f);
    rd_chk(HIU_OFF_INPUT_CTL, 8'h80);
    pol = 1'b1;
    chk1("line", 1'b0, host_int);
    pulse(9'h003);
    chk1("line", 1'b1, host_int);
    wr(HIU_OFF_FLAGS, 8'h03);
  endtask
  task automatic t_ext;
    for (int m = 0; m < 4; m++) begin
      ext_pin = EXT_IDLE[m];
      wr(HIU_OFF_INPUT_CTL, {2'b10, 2'(m), 4'h0});
      repeat (4) tick;
      wr(HIU_OFF_FLAGS, 8'h40);
      rd_chk(HIU_OFF_FLAGS, 8'h00);
      ext_pin = ~EXT_IDLE[m];
      repeat (4) tick;
      rd_chk(HIU_OFF_FLAGS, 8'h40);
      chk1("line", 1'b1, host_int);
    end
    // Short glitch must be filtered, a steady level must pass
    ext_pin = 1'b0;
    wr(HIU_OFF_INPUT_CTL, 8'hf0);
    repeat (12) tick;
    wr(HIU_OFF_FLAGS, 8'h40);
    ext_pin = 1'b1;
    repeat (3) tick;
    ext_pin = 1'b0;
    repeat (12) tick;
    rd_chk(HIU_OFF_FLAGS, 8'h00);
    ext_pin = 1'b1;
    repeat (DEB + 6) tick;
    rd_chk(HIU_OFF_FLAGS, 8'h40);
  endtask

  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop;
  end

  initial begin
    rst_n = 1'b0;
    ext_pin = 1'b1;
    pol = 1'b0;
    src_v = '0;
    req = '{1'b0, 8'h00, 8'h00};
    fails = 0;
    checks_done = 0;
    repeat (5) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_sources;
    t_disabled;
    t_mask;
    t_polarity;
    t_ext;
    report_and_stop;
  end
endmodule
